// ===== src/wdr_top.sv
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - variant one: system/8192 or sub/32
// - variant two: mode source or sub/32
// - run on protected write, enable already set
// - variant two runs from reset release
// - tick at all-ones overflows, internal reset
// - internal reset lasts 512 oscillator cycles
// - counter writable, counts from written value
// - variant one sub-active needs sub/32 source
// - variant one low-power halts, registers hold
// - variant two low-power needs sub/32 or oscillator
// - variant two standby needs oscillator; module standby halts
// - protected bits need write-inhibit zero, enable
// - overflow sets flag; protected clear only
// - mode code selects system divide or oscillator
// - clearing run bit halts, keeps count
module wdr_top
    import wdr_pkg::*;
#(
    parameter bit VARIANT_TWO = 1'b0,
    parameter int RST_OSC_CYCLES = wdr_pkg::OSC_RESET_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic sub_tick_i,
    input wire logic osc_tick_i,
    input wire wdr_pkg::wdr_power_t power_i,
    input wire wdr_pkg::wdr_wb_req_t wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wdt_int_reset_o,
    output logic irq_o
);
    import wdr_pkg::*;

    // ==========================================
    // bus decode
    logic ack_q;
    logic [31:0] rdat_q;
    // ack_q in the take term keeps one request from being taken twice
    wire acc = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
    wire wr = acc & wb_req_i.we & wb_req_i.sel[0];
    wire [7:0] wd = wb_req_i.dat[7:0];
    wire sel_ctrl = wb_req_i.adr == {2'b00, ADDR_CTRL};
    wire sel_count = wb_req_i.adr == {2'b00, ADDR_COUNT};
    wire sel_mode = (wb_req_i.adr == {2'b00, ADDR_MODE}) & VARIANT_TWO;
    wire sel_pmode = wb_req_i.adr == {2'b00, ADDR_PMODE};
    wire sel_icl = wb_req_i.adr == ADDR_ICLR;
    wire sel_ien = wb_req_i.adr == ADDR_IEN;
    wire sel_ist = wb_req_i.adr == ADDR_ISTAT;

    // ==========================================
    // registers
    // count and mode hold their value across every halted power state
    logic we_q;
    logic run_q;
    logic flag_q;
    logic clk_sel_q;
    logic [3:0] mode_q;
    logic [7:0] count_q;
    logic [PRE_W-1:0] pre_q;
    logic [4:0] sub_pre_q;
    logic [9:0] rst_cnt_q;
    logic rst_act_q;
    logic [1:0] ist_q;
    logic [1:0] ien_q;

    // ==========================================
    // clock source selection
    // oscillator for codes 0xxx
    wire use_osc = VARIANT_TWO & ~clk_sel_q & ~mode_q[3];
    wire [3:0] div_log2 = 4'(SEL_DIV_BASE_LOG2) + {1'b0, mode_q[2:0]};
    wire [PRE_W-1:0] sel_mask = PRE_W'((1 << div_log2) - 1);
    wire [PRE_W-1:0] fix_mask = PRE_W'(FIXED_DIV - 1);
    // masks on one free-running counter give every system-clock ratio without extra counters
    wire [PRE_W-1:0] div_mask = VARIANT_TWO ? sel_mask : fix_mask;
    wire sys_tick = (pre_q & div_mask) == '0;
    // sub/32 fires on every 32nd sub-clock pulse
    wire sub_tick = sub_tick_i & (sub_pre_q == 5'(SUB_DIV - 1));
    logic src_tick;
    always_comb begin
        if (clk_sel_q) begin
            src_tick = sub_tick;
        end else if (use_osc) begin
            src_tick = osc_tick_i;
        end else begin
            src_tick = sys_tick;
        end
    end

    // ==========================================
    // operating-state gating
    // power state only gates the block; it never clears watchdog state
    logic op_ok;
    always_comb begin
        op_ok = 1'b1;
        if (power_i.mod_standby) begin
            op_ok = 1'b0;
        end else if (!VARIANT_TWO) begin
            if (power_i.standby) begin
                op_ok = 1'b0;
            end else if (power_i.mode == WDR_PM_SUBACT) begin
                op_ok = clk_sel_q;
            end else if (power_i.mode != WDR_PM_ACTIVE && power_i.mode != WDR_PM_SLEEP) begin
                op_ok = 1'b0;
            end
        end else begin
            if (power_i.standby) begin
                op_ok = use_osc;
            end else if (power_i.mode != WDR_PM_ACTIVE && power_i.mode != WDR_PM_SLEEP) begin
                op_ok = clk_sel_q | use_osc;
            end
        end
    end

    // control, count and mode writes that arrive while halted are acknowledged but dropped
    wire run = ce_i & op_ok;
    wire wr_ok = wr & run;
    wire ctrl_wr = wr_ok & sel_ctrl;
    // write enable and its inhibit bit
    wire we_wr = ctrl_wr & ~wd[BIT_ENA_WI];
    // protected bits need write enable already set
    wire run_wr = ctrl_wr & we_q & ~wd[BIT_RUN_WI];
    wire flag_clr = ctrl_wr & we_q & ~wd[BIT_FLAG_WI] & ~wd[BIT_FLAG];
    wire count_wr = wr_ok & sel_count;
    wire mode_wr = wr_ok & sel_mode;
    // source select stays writable in every power state to wake a halted counter
    wire pmode_wr = wr & sel_pmode;
    wire cnt_tick = run & run_q & src_tick;
    wire ovf = cnt_tick & (count_q == COUNT_MAX);
    wire rst_done = ce_i & rst_act_q & osc_tick_i & (rst_cnt_q == 10'(RST_OSC_CYCLES - 1));

    // ==========================================
    // prescalers run freely while the block is clocked
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q <= '0;
        end else if (ce_i) begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // the sub-clock divider only advances on sub-clock pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sub_pre_q <= '0;
        end else if (ce_i && sub_tick_i) begin
            sub_pre_q <= sub_pre_q + 1'b1;
        end
    end

    // ==========================================
    // control/status register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            we_q <= 1'b0;
        end else if (ce_i && we_wr) begin
            we_q <= wd[BIT_WE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= VARIANT_TWO;
        end else if (ce_i && run_wr) begin
            run_q <= wd[BIT_RUN];
        end
    end

    // overflow is tested first so a racing clear cannot lose the event
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (ce_i) begin
            if (ovf) begin
                flag_q <= 1'b1;
            end else if (flag_clr) begin
                flag_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // counter, mode and source select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= COUNT_RESET;
        end else if (ce_i) begin
            if (count_wr) begin
                count_q <= wd;
            end else if (cnt_tick) begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= MODE_RESET;
        end else if (ce_i && mode_wr) begin
            mode_q <= wd[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_sel_q <= 1'b0;
        end else if (ce_i && pmode_wr) begin
            clk_sel_q <= wd[BIT_CLK_SEL];
        end
    end

    // ==========================================
    // internal reset pulse
    // 512 oscillator cycles
    // a second overflow inside the pulse is not allowed to stretch it
    wire rst_start = ovf & ~rst_act_q;
    wire rst_step = rst_act_q & osc_tick_i;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_act_q <= 1'b0;
        end else if (ce_i) begin
            if (rst_start) begin
                rst_act_q <= 1'b1;
            end else if (rst_done) begin
                rst_act_q <= 1'b0;
            end
        end
    end

    // the length counter restarts with every new pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_cnt_q <= '0;
        end else if (ce_i) begin
            if (rst_start) begin
                rst_cnt_q <= '0;
            end else if (rst_step) begin
                rst_cnt_q <= rst_cnt_q + 1'b1;
            end
        end
    end

    // ==========================================
    // interrupt status, clear and enable
    wire [1:0] ev = {rst_done, ovf};
    wire [1:0] iclr = (wr && sel_icl) ? wd[1:0] : 2'b00;
    wire ien_wr = wr & sel_ien;
    logic [1:0] ist_d;
    // one sticky bit per event; events win over a same-cycle clear
    for (genvar gi = 0; gi < 2; gi++) begin : g_irq
        assign ist_d[gi] = (ist_q[gi] & ~iclr[gi]) | ev[gi];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_q <= '0;
        end else if (ce_i) begin
            ist_q <= ist_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ien_q <= '0;
        end else if (ce_i && ien_wr) begin
            ien_q <= wd[1:0];
        end
    end

    // ==========================================
    // read data and acknowledge
    // bits 5, 3 and 1 are the inhibit bits, which always read back as one
    wire [7:0] ctrl_rd = {2'b00, 1'b1, we_q, 1'b1, run_q, 1'b1, flag_q};
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        if (sel_ctrl) begin
            rmux = {24'h000000, ctrl_rd};
        end
        if (sel_count) begin
            rmux = {24'h000000, count_q};
        end
        if (sel_mode) begin
            rmux = {24'h000000, MODE_RSVD | {4'h0, mode_q}};
        end
        if (sel_pmode) begin
            rmux = {31'h0, clk_sel_q};
        end
        if (sel_ist) begin
            rmux = {30'h0, ist_q};
        end
        if (sel_ien) begin
            rmux = {30'h0, ien_q};
        end
    end

    // ack ignores the clock enable so a frozen block never hangs the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= '0;
        end else if (acc) begin
            rdat_q <= rmux;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign wdt_int_reset_o = rst_act_q;
    // a level from registers: it holds until software clears the status
    assign irq_o = |(ist_q & ien_q);
endmodule
`default_nettype wire

// ===== src/wdr_pkg.sv
package wdr_pkg;
    // ==========================================
    // register offsets (byte addresses, one word each)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_COUNT = 4'h4;
    localparam logic [3:0] ADDR_MODE = 4'h8;
    localparam logic [3:0] ADDR_PMODE = 4'hc;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h0 + 4'h0;
    // ==========================================
    // control/status and source-select field positions
    localparam int BIT_ENA_WI = 5;
    localparam int BIT_WE = 4;
    localparam int BIT_RUN_WI = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_FLAG_WI = 1;
    localparam int BIT_FLAG = 0;
    localparam int BIT_CLK_SEL = 0;
    // ==========================================
    // mode register, counter values, prescale and internal reset length
    localparam logic [3:0] MODE_RESET = 4'hf;
    localparam logic [7:0] MODE_RSVD = 8'hf0;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam int FIXED_DIV = 8192;
    localparam int SUB_DIV = 32;
    localparam int SEL_DIV_BASE_LOG2 = 6;
    localparam int OSC_RESET_CYCLES = 512;
    localparam int PRE_W = 13;
    // ==========================================
    // second address bank: interrupt status/clear/enable
    localparam logic [5:0] ADDR_ISTAT = 6'h10;
    localparam logic [5:0] ADDR_ICLR = 6'h14;
    localparam logic [5:0] ADDR_IEN = 6'h18;
    localparam int IRQ_OVF = 0;
    localparam int IRQ_RST_END = 1;

    typedef enum logic [4:0] {
        WDR_PM_ACTIVE = 5'b00001,
        WDR_PM_SLEEP = 5'b00010,
        WDR_PM_WATCH = 5'b00100,
        WDR_PM_SUBACT = 5'b01000,
        WDR_PM_SUBSLP = 5'b10000
    } wdr_pmode_t;

    typedef struct packed {
        logic standby;
        logic mod_standby;
        wdr_pmode_t mode;
    } wdr_power_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [5:0] adr;
        logic [31:0] dat;
    } wdr_wb_req_t;
endpackage

// ===== verif/wdr_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module wdr_top_asserts
    import wdr_pkg::*;
#(
    parameter int RST_OSC_CYCLES = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic osc_tick_i,
    input wire wdr_pkg::wdr_power_t power_i,
    input wire wdr_pkg::wdr_wb_req_t wb_req_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wdt_int_reset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // helper
    // oscillator ticks seen while the internal reset stands
    logic [15:0] osc_n_q;
    wire logic take = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    wire logic rd_take = take && !wb_req_i.we;
    always_ff @(posedge clk_i) begin
        if (rst_i || !wdt_int_reset_o) begin
            osc_n_q <= 16'h0;
        end else if (osc_tick_i && ce_i) begin
            osc_n_q <= osc_n_q + 16'h1;
        end
    end
    // ==========================================
    // properties
    property p_ack_one;
        take |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack not one cycle after request");
    property p_ack_cause;
        $rose(wb_ack_o) |-> $past(take);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_ctrl_ones;
        rd_take && wb_req_i.adr == 6'h00 |=> (wb_dat_o[7:0] & 8'haa) == 8'h2a;
    endproperty
    a_ctrl_ones: assert property (p_ctrl_ones) else $error("ctrl fixed bits wrong");
    property p_unmapped;
        rd_take && wb_req_i.adr == 6'h3c |=> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rst_len;
        wdt_int_reset_o |-> osc_n_q < RST_OSC_CYCLES;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("internal reset too long");
    property p_rst_fall;
        $fell(wdt_int_reset_o) |-> $past(osc_n_q) == RST_OSC_CYCLES - 1;
    endproperty
    a_rst_fall: assert property (p_rst_fall) else $error("internal reset too short");
    property p_mstb;
        power_i.mod_standby && !wdt_int_reset_o |=> !wdt_int_reset_o;
    endproperty
    a_mstb: assert property (p_mstb) else $error("overflow in module standby");
    property p_ce_frz;
        !ce_i && !wdt_int_reset_o |=> !wdt_int_reset_o;
    endproperty
    a_ce_frz: assert property (p_ce_frz) else $error("overflow while frozen");
endmodule
`default_nettype wire

// ===== verif/wdr_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module wdr_top_tb;
    import wdr_pkg::*;
    logic clk_i, rst_i, ce_i, sub_tick_i, osc_tick_i, wb_ack_o, wdt_int_reset_o, irq_o;
    wdr_power_t power_i;
    wdr_wb_req_t wb_req_i;
    logic [31:0] wb_dat_o, rd;
    int mismatches = 0;
    int comparisons = 0;
    int n;
    logic [7:0] a;
    wdr_top #(.VARIANT_TWO(1'b0), .RST_OSC_CYCLES(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(ce_i), .sub_tick_i(sub_tick_i), .osc_tick_i(osc_tick_i), .power_i(power_i),
        .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wdt_int_reset_o(wdt_int_reset_o), .irq_o(irq_o));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic complete_run();
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one classic cycle; entered and left just after a rising edge
    task automatic wb(input logic w, input logic [5:0] ad, input logic [7:0] d);
        wb_req_i <= '{cyc:1'b1, stb:1'b1, we:w, sel:4'hf, adr:ad, dat:{24'h0, d}};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        chk("ack", {31'h0, wb_ack_o}, 32'h1);
        if (n >= 20) complete_run();
        rd = wb_dat_o;
        wb_req_i <= '0;
        @(posedge clk_i);
    endtask
    task automatic t_protect();
        wb(1'b0, 6'h04, 8'h0);
        chk("count", rd, 32'h0);
        wb(1'b1, 6'h00, 8'h34);
        wb(1'b0, 6'h00, 8'h0);
        chk("ctrl", rd, 32'h2a);
        wb(1'b0, 6'h3c, 8'h0);
        wb(1'b1, 6'h00, 8'h10);
        wb(1'b0, 6'h00, 8'h0);
        chk("ctrl", rd, 32'h3a);
        wb(1'b1, 6'h00, 8'h24);
        wb(1'b0, 6'h00, 8'h0);
        chk("ctrl", rd, 32'h3e);
    endtask
    task automatic t_overflow();
        wb(1'b1, 6'h18, 8'h01);
        wb(1'b1, 6'h0c, 8'h01);
        wb(1'b1, 6'h04, 8'hfe);
        n = 0;
        while (wdt_int_reset_o !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk("ovf late", n < 300, 1);
        chk("ovf early", n > 30, 1);
        if (n >= 300) complete_run();
        n = 0;
        while (wdt_int_reset_o === 1'b1 && n < 600) begin
            @(posedge clk_i);
            n++;
        end
        chk("rst len", n, 4);
        chk("irq", irq_o, 1);
        wb(1'b0, 6'h00, 8'h0);
        chk("ctrl", rd, 32'h3f);
        wb(1'b1, 6'h14, 8'h01);
        chk("irq", irq_o, 0);
        wb(1'b1, 6'h00, 8'h2c);
        wb(1'b0, 6'h00, 8'h0);
        chk("ctrl", rd, 32'h3e);
    endtask
    task automatic t_halt();
        power_i <= '{standby:1'b0, mod_standby:1'b1, mode:WDR_PM_WATCH};
        wb(1'b0, 6'h04, 8'h0);
        a = rd[7:0];
        repeat (100) @(posedge clk_i);
        wb(1'b1, 6'h04, 8'h55);
        wb(1'b0, 6'h04, 8'h0);
        chk("count", rd, {24'h0, a});
        power_i <= '{standby:1'b0, mod_standby:1'b0, mode:WDR_PM_ACTIVE};
        wb(1'b1, 6'h00, 8'h22);
        wb(1'b0, 6'h04, 8'h0);
        a = rd[7:0];
        repeat (100) @(posedge clk_i);
        ce_i <= 1'b0;
        wb(1'b1, 6'h04, 8'h55);
        ce_i <= 1'b1;
        wb(1'b0, 6'h04, 8'h0);
        chk("count", rd, {24'h0, a});
        wb(1'b1, 6'h04, 8'h55);
        wb(1'b0, 6'h04, 8'h0);
        chk("count", rd, 32'h55);
    endtask
    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        sub_tick_i = 1'b1;
        osc_tick_i = 1'b1;
        power_i = '{standby:1'b0, mod_standby:1'b0, mode:WDR_PM_ACTIVE};
        wb_req_i = '0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_protect();
        t_overflow();
        t_halt();
        complete_run();
    end
endmodule
bind wdr_top wdr_top_asserts #(.RST_OSC_CYCLES(RST_OSC_CYCLES)) u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(ce_i), .osc_tick_i(osc_tick_i), .power_i(power_i),
    .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wdt_int_reset_o(wdt_int_reset_o));
`default_nettype wire
